// ### rtl/ecs_pkg.sv
// Shared constants and types for the external oscillator clock select block.
package ecs_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_EXT_CTL = 8'h00;
  localparam logic [7:0] OFS_INT_CTL = 8'h04;

  // Values after reset.
  localparam logic [7:0] EXT_CTL_RST = 8'h00;
  localparam logic [7:0] INT_CTL_RST = 8'h14;

  // Field positions in the external-oscillator control register.
  localparam int EXT_VALID_BIT = 7;
  localparam int EXT_MODE_LSB = 4;
  localparam int EXT_RSV_BIT = 3;
  localparam int EXT_RANGE_LSB = 0;

  // Field positions in the internal-oscillator control register.
  localparam int INT_READY_BIT = 4;
  localparam int INT_SEL_BIT = 3;
  localparam int INT_EN_BIT = 2;
  localparam int INT_DIV_LSB = 0;

  // Oscillator mode codes; off is 00x.
  localparam logic [2:0] MODE_CMOS = 3'h2;
  localparam logic [2:0] MODE_CMOS_D2 = 3'h3;
  localparam logic [2:0] MODE_RC_D2 = 3'h4;
  localparam logic [2:0] MODE_CAP_D2 = 3'h5;
  localparam logic [2:0] MODE_XTAL = 3'h6;
  localparam logic [2:0] MODE_XTAL_D2 = 3'h7;
  localparam logic [1:0] MODE_GRP_OFF = 2'h0;
  localparam logic [1:0] MODE_GRP_XTAL = 2'h3;

  // Internal divider terminal counts for codes 00, 01, 10, 11.
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV1_LAST = 3'h0;

  // Timing at the 250 MHz reference clock.
  localparam int CLK_PERIOD_PS = 4000;
  localparam int INT_START_NS = 100;
  localparam int INT_START_CYC =
    (INT_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [15:0] XTAL_SETTLE_EDGES = 16'h0100;
  localparam logic [11:0] XTAL_GAP_LIMIT = 12'hFFF;

  typedef enum logic [1:0] {
    SRC_INT,
    SRC_EXT,
    SRC_WAIT
  } ecs_src_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] range;
  } ecs_ext_ctl_t;

  typedef struct packed {
    logic sel_ext;
    logic int_en;
    logic [1:0] div;
  } ecs_int_ctl_t;

  typedef struct packed {
    logic claim_a;
    logic claim_b;
  } ecs_pins_t;

endpackage

// ### rtl/ecs_pin_sync.sv
// Three-stage pin synchroniser with a rising-edge pulse.
`timescale 1ns/1ns
module ecs_pin_sync
  import ecs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pin and result
  input wire logic pin_in,
  output logic rise_q
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } ecs_sync_t;

  ecs_sync_t q;
  ecs_sync_t d;

  // A change counts only once the second and third stages agree.
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rise = 1'b0;
    if (q.s2 == q.s3) begin
      d.level = q.s3;
      d.rise = q.s3 && !q.level;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise_q = q.rise;

endmodule

// ### rtl/ecs_clock_ctl.sv
// External oscillator control, clock source select and APB registers.
//
// How it works
// - System clock from external when select is 1 and external runs; stays external while internal is off.
// - External ticks always offered to peripherals.
// - Source switch only once target oscillator runs.
// - One write enables and selects internal oscillator.
// - Hardware sets crystal-valid once oscillator settled.
// - Valid bit 7 reads zero outside crystal modes.
// - Mode field bits 6-4 decoded per code.
// - Range field bits 2-0 drives oscillator bias.
// - Bit 3 reads zero, writes ignored.
// - Crystal modes claim both crystal pins.
// - Other running modes claim pin b only.
// - Select bit 3: 0 internal, 1 external.
// - Bit 2 enables the internal oscillator.
// - Internal divider: 00/8, 01/4, 10/2, 11/1.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module ecs_clock_ctl
  import ecs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator pin
  input wire logic crystal_pin_b_in,
  // Oscillator drive and pin ownership
  output logic [2:0] ext_osc_freq_range,
  output logic [2:0] ext_osc_mode_field,
  output logic internal_osc_enable,
  output logic crystal_pin_a_claim,
  output logic crystal_pin_b_claim,
  // Clock enables
  output logic system_clock_en,
  output logic periph_ext_clock_en
);

  typedef struct packed {
    ecs_ext_ctl_t ext;
    ecs_int_ctl_t ictl;
    ecs_src_t src;
    logic [2:0] div_cnt;
    logic ext_half;
    logic [15:0] edge_cnt;
    logic [11:0] gap_cnt;
    logic xvalid;
    logic [7:0] start_cnt;
    logic irdy;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sys_en;
    logic per_en;
    ecs_pins_t pins;
  } ecs_state_t;

  ecs_state_t q;
  ecs_state_t d;
  logic ext_rise;
  logic [2:0] div_last;
  logic int_tick;
  logic ext_tick;
  logic xtal_mode;
  logic ext_on;
  logic div2_mode;
  logic acc;
  logic wr_ext;
  logic wr_int;
  logic hit;

  ecs_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(crystal_pin_b_in),
    .rise_q(ext_rise)
  );

  always_comb begin
    case (q.ictl.div)
      2'b00: div_last = DIV8_LAST;
      2'b01: div_last = DIV4_LAST;
      2'b10: div_last = DIV2_LAST;
      default: div_last = DIV1_LAST;
    endcase
  end

  assign xtal_mode = (q.ext.mode[2:1] == MODE_GRP_XTAL);
  assign ext_on = (q.ext.mode[2:1] != MODE_GRP_OFF);
  // Only plain CMOS and plain crystal skip the divide-by-two stage.
  assign div2_mode = (q.ext.mode != MODE_CMOS) && (q.ext.mode != MODE_XTAL);
  assign int_tick = q.ictl.int_en && (q.div_cnt == div_last);
  assign ext_tick = ext_on && ext_rise && (!div2_mode || q.ext_half);
  assign acc = psel && penable && q.pready;
  assign hit = (paddr == OFS_EXT_CTL) || (paddr == OFS_INT_CTL);
  assign wr_ext = acc && pwrite && (paddr == OFS_EXT_CTL);
  assign wr_int = acc && pwrite && (paddr == OFS_INT_CTL);

  always_comb begin
    d = q;
    // APB: one wait state, answer on the second access cycle.
    d.pready = psel && penable && !q.pready;
    d.pslverr = psel && penable && !q.pready && !hit;
    d.prdata = '0;
    if (psel && penable && !q.pready && !pwrite) begin
      if (paddr == OFS_EXT_CTL) begin
        d.prdata[EXT_VALID_BIT] = q.xvalid && xtal_mode;
        d.prdata[EXT_MODE_LSB +: 3] = q.ext.mode;
        d.prdata[EXT_RSV_BIT] = 1'b0;
        d.prdata[EXT_RANGE_LSB +: 3] = q.ext.range;
      end else if (paddr == OFS_INT_CTL) begin
        d.prdata[INT_READY_BIT] = q.irdy;
        d.prdata[INT_SEL_BIT] = q.ictl.sel_ext;
        d.prdata[INT_EN_BIT] = q.ictl.int_en;
        d.prdata[INT_DIV_LSB +: 2] = q.ictl.div;
      end
    end
    if (wr_ext) begin
      d.ext.mode = pwdata[EXT_MODE_LSB +: 3];
      d.ext.range = pwdata[EXT_RANGE_LSB +: 3];
    end
    if (wr_int) begin
      // Enable and select land together in one write.
      d.ictl.sel_ext = pwdata[INT_SEL_BIT];
      d.ictl.int_en = pwdata[INT_EN_BIT];
      d.ictl.div = pwdata[INT_DIV_LSB +: 2];
    end

    // Internal divider runs only while the internal oscillator is on.
    if (!q.ictl.int_en || int_tick || q.div_cnt > div_last) begin
      d.div_cnt = 3'h0;
    end else begin
      d.div_cnt = q.div_cnt + 3'h1;
    end
    if (!q.ictl.int_en) begin
      d.start_cnt = '0;
      d.irdy = 1'b0;
    end else if (q.start_cnt == 8'(INT_START_CYC)) begin
      d.irdy = 1'b1;
    end else begin
      d.start_cnt = q.start_cnt + 8'h01;
    end

    if (!ext_on) begin
      d.ext_half = 1'b0;
    end else if (ext_rise) begin
      d.ext_half = !q.ext_half;
    end

    // Crystal settle detector: enough edges with no long gap.
    if (!xtal_mode) begin
      d.edge_cnt = '0;
      d.gap_cnt = '0;
      d.xvalid = 1'b0;
    end else if (ext_rise) begin
      d.gap_cnt = '0;
      if (q.edge_cnt != XTAL_SETTLE_EDGES) begin
        d.edge_cnt = q.edge_cnt + 16'h0001;
      end else begin
        d.xvalid = 1'b1;
      end
    end else if (q.gap_cnt == XTAL_GAP_LIMIT) begin
      d.edge_cnt = '0;
      d.xvalid = 1'b0;
    end else begin
      d.gap_cnt = q.gap_cnt + 12'h001;
    end

    d.per_en = ext_tick;
    d.sys_en = 1'b0;
    // A change waits for the new source's first whole tick and drops the
    // old one, so no shortened period reaches the system clock.
    case (q.src)
      SRC_INT: begin
        d.sys_en = int_tick;
        if (q.ictl.sel_ext && ext_on) begin
          d.src = SRC_WAIT;
          d.sys_en = 1'b0;
        end
      end
      SRC_EXT: begin
        d.sys_en = ext_tick;
        if (!q.ictl.sel_ext && q.ictl.int_en) begin
          d.src = SRC_WAIT;
          d.sys_en = 1'b0;
        end
      end
      SRC_WAIT: begin
        if (q.ictl.sel_ext && ext_tick) begin
          d.src = SRC_EXT;
          d.sys_en = 1'b1;
        end else if (!q.ictl.sel_ext && int_tick) begin
          d.src = SRC_INT;
          d.sys_en = 1'b1;
        end
      end
      default: d.src = SRC_INT;
    endcase

    d.pins.claim_a = xtal_mode;
    d.pins.claim_b = ext_on;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.ext.mode <= EXT_CTL_RST[EXT_MODE_LSB +: 3];
      q.ext.range <= EXT_CTL_RST[EXT_RANGE_LSB +: 3];
      q.ictl <= ecs_int_ctl_t'(INT_CTL_RST[3:0]);
      // The internal oscillator runs out of reset, so it reads as ready.
      q.start_cnt <= 8'(INT_START_CYC);
      q.irdy <= INT_CTL_RST[INT_READY_BIT];
      q.src <= SRC_INT;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign ext_osc_freq_range = q.ext.range;
  assign ext_osc_mode_field = q.ext.mode;
  assign internal_osc_enable = q.ictl.int_en;
  assign crystal_pin_a_claim = q.pins.claim_a;
  assign crystal_pin_b_claim = q.pins.claim_b;
  assign system_clock_en = q.sys_en;
  assign periph_ext_clock_en = q.per_en;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  ext_select_a: assert property (
    (q.src == SRC_EXT) |-> q.ictl.sel_ext || $past(q.ictl.sel_ext))
    else $error("external source active without select");

  periph_tick_a: assert property (
    (ext_on && ext_rise && !div2_mode) |=> q.per_en)
    else $error("peripheral tick missing in undivided mode");

  int_wait_a: assert property (
    (wr_int && pwdata[INT_EN_BIT] && !pwdata[INT_SEL_BIT]
     && q.src == SRC_EXT) |-> ##[1:12] (q.src == SRC_INT))
    else $error("internal select did not take effect");

  valid_set_a: assert property (
    $rose(q.xvalid) |-> $past(q.edge_cnt) == XTAL_SETTLE_EDGES)
    else $error("valid set before settle count");

  valid_read_a: assert property (
    (psel && penable && !q.pready && !pwrite && paddr == OFS_EXT_CTL
     && !xtal_mode) |=> !q.prdata[EXT_VALID_BIT])
    else $error("valid bit read high outside crystal mode");

  rsv_zero_a: assert property (
    q.pready |-> !q.prdata[EXT_RSV_BIT] || $past(paddr) != OFS_EXT_CTL)
    else $error("reserved bit read nonzero");

  pin_claim_a: assert property (
    (xtal_mode && $stable(q.ext.mode)) |->
      q.pins.claim_a && q.pins.claim_b)
    else $error("crystal pins not claimed");

  pin_b_only_a: assert property (
    (ext_on && !xtal_mode && $stable(q.ext.mode)) |->
      !q.pins.claim_a && q.pins.claim_b)
    else $error("wrong pin claim in single pin mode");

  int_div_a: assert property (
    (q.src == SRC_INT && q.ictl.int_en && q.ictl.div == 2'b00
     && q.div_cnt == 3'h7 && !q.ictl.sel_ext) |=> q.sys_en)
    else $error("divide by eight tick missing");

  int_off_a: assert property (
    (q.sys_en && q.src == SRC_INT) |-> $past(q.ictl.int_en))
    else $error("internal tick while disabled");

  no_runt_a: assert property (
    (q.src == SRC_WAIT && $past(q.src) == SRC_WAIT) |-> !q.sys_en)
    else $error("system tick during source change");

  cov_to_ext_c: cover property ($rose(q.src == SRC_EXT));
  cov_to_int_c: cover property (
    $past(q.src) == SRC_WAIT && q.src == SRC_INT);
  cov_valid_c: cover property ($rose(q.xvalid));
  cov_half_c: cover property (ext_tick && div2_mode && !xtal_mode);

endmodule

// ### bench/ecs_osc_model.sv
// Behavioural external oscillator that drives the oscillator input pin.
`timescale 1ns/1ns
module ecs_osc_model #(
  parameter int HALF_NS = 16
) (
  // Control
  input wire logic run,
  // Pin
  output logic pin
);
  // The pin sits low while unclaimed, so that no stray edge is counted.
  initial begin
    pin = 1'b0;
    forever begin
      #HALF_NS;
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking bench for the oscillator control and clock select block.
`timescale 1ns/1ns
module tb;
  import ecs_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, pin_b, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] range_o, mode_o;
  logic int_en, claim_a, claim_b, sys_en, per_en, err;
  int error_cnt, n_tests, cyc, s_cnt, p_cnt;

  ecs_clock_ctl u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_pin_b_in(pin_b), .ext_osc_freq_range(range_o),
    .ext_osc_mode_field(mode_o), .internal_osc_enable(int_en),
    .crystal_pin_a_claim(claim_a), .crystal_pin_b_claim(claim_b),
    .system_clock_en(sys_en), .periph_ext_clock_en(per_en));

  // The pin toggles every 4 ns cycle times four, one edge per 8 cycles.
  // The oscillator drives the pin only while the block claims it.
  ecs_osc_model u_osc (.run(claim_b), .pin(pin_b));

  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle follows so psel never toggles twice.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer.
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic ticks(input int n);
    s_cnt = 0;
    p_cnt = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (sys_en === 1'b1) s_cnt++;
      if (per_en === 1'b1) p_cnt++;
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, OFS_INT_CTL, 32'h0);
    chk(rdat, 32'h00000014);
    apb(1'b0, OFS_EXT_CTL, 32'h0);
    chk(rdat, 32'h00000000);
    apb(1'b1, OFS_EXT_CTL, 32'h0000002D);
    apb(1'b0, OFS_EXT_CTL, 32'h0);
    chk(rdat, 32'h00000025);
    chk({mode_o, range_o}, 32'h15);
    chk({claim_a, claim_b}, 32'h1);
    apb(1'b1, OFS_EXT_CTL, 32'h00000008);
    apb(1'b0, OFS_EXT_CTL, 32'h0);
    chk(rdat, 32'h00000000);
    chk({claim_a, claim_b}, 32'h0);
    apb(1'b1, 8'h08, 32'h000000FF);
    chk(err, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(err, 1'b1);
    chk(rdat, 32'h00000000);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, OFS_INT_CTL, 32'h14 | d);
      ticks(16);
      ticks(64);
      chk(s_cnt, 8 << d);
    end
    chk(int_en, 1'b1);
    // Selecting the external source with the oscillator off must not stop
    // the system clock; the block stays on the internal source.
    apb(1'b1, OFS_INT_CTL, 32'h0000001F);
    ticks(16);
    ticks(64);
    chk(s_cnt, 64);
    apb(1'b1, OFS_INT_CTL, 32'h00000017);
    apb(1'b1, OFS_EXT_CTL, 32'h00000067);
    apb(1'b0, OFS_EXT_CTL, 32'h0);
    chk({claim_a, claim_b}, 32'h3);
    chk(rdat, 32'h00000067);
    for (int i = 0; i < 1000 && rdat[7] !== 1'b1; i++) begin
      apb(1'b0, OFS_EXT_CTL, 32'h0);
    end
    chk(rdat, 32'h000000E7);
    apb(1'b1, OFS_INT_CTL, 32'h0000001F);
    ticks(32);
    ticks(200);
    chk(s_cnt, p_cnt);
    chk(p_cnt >= 24 && p_cnt <= 26, 1'b1);
    // Turn the internal oscillator off while running from the crystal.
    apb(1'b1, OFS_INT_CTL, 32'h0000001B);
    apb(1'b0, OFS_INT_CTL, 32'h0);
    chk(rdat, 32'h0000000B);
    chk(int_en, 1'b0);
    apb(1'b1, OFS_INT_CTL, 32'h00000017);
    ticks(32);
    ticks(64);
    chk(s_cnt, 64);
    chk(p_cnt > 0, 1'b1);
    apb(1'b1, OFS_EXT_CTL, 32'h00000077);
    ticks(32);
    ticks(256);
    chk(p_cnt >= 15 && p_cnt <= 17, 1'b1);
    apb(1'b0, OFS_EXT_CTL, 32'h0);
    chk(rdat, 32'h000000F7);
    apb(1'b1, OFS_EXT_CTL, 32'h00000027);
    apb(1'b0, OFS_EXT_CTL, 32'h0);
    chk(rdat, 32'h00000027);
    chk({claim_a, claim_b}, 32'h1);
    // The divided single-pin modes pass every second edge.
    for (int m = 3; m < 6; m++) begin
      apb(1'b1, OFS_EXT_CTL, (m << 4) | 32'h0000000B);
      ticks(32);
      ticks(256);
      chk(p_cnt >= 15 && p_cnt <= 17, 1'b1);
      apb(1'b0, OFS_EXT_CTL, 32'h0);
      chk(rdat, (m << 4) | 32'h00000003);
      chk({claim_a, claim_b}, 32'h1);
    end
    apb(1'b1, OFS_EXT_CTL, 32'h00000012);
    ticks(32);
    ticks(64);
    chk(p_cnt, 32'h0);
    chk({claim_a, claim_b}, 32'h0);
    finish_test();
  end
endmodule
